// ===== rtl/pwmtb_pkg.sv
// Package for the PWM time-base selector: offsets, fields, encodings
package pwmtb_pkg;
  // Register byte offsets (word aligned)
  localparam logic [3:0] PWMTB_OFS_SELECT_A = 4'h0;
  localparam logic [3:0] PWMTB_OFS_SELECT_B = 4'h4;
  // Reset values
  localparam logic [7:0] PWMTB_RST_SELECT_A = 8'h00;
  localparam logic [7:0] PWMTB_RST_SELECT_B = 8'h00;
  // Field positions (low bit of each 2-bit selector)
  localparam int PWMTB_POS_CH1 = 0;
  localparam int PWMTB_POS_CH2 = 2;
  localparam int PWMTB_POS_CH3 = 4;
  localparam int PWMTB_POS_CH4 = 6;
  localparam int PWMTB_POS_CH5 = 0;
  // Selector encodings
  localparam logic [1:0] PWMTB_SEL_TMR2 = 2'h0;
  localparam logic [1:0] PWMTB_SEL_TMR4 = 2'h1;
  localparam logic [1:0] PWMTB_SEL_TMR6 = 2'h2;
  localparam logic [1:0] PWMTB_SEL_RSVD = 2'h3;
endpackage : pwmtb_pkg

// ===== rtl/pwm_timebase_select.sv
// Time-base selector for five PWM channels with a classic Wishbone slave
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// - Channel 4 follows its selector in PWM
// - Channel 3 follows its selector in PWM
// - Channel 2 follows its selector in PWM
// - Channel 1 follows its selector in PWM
// - Register A packs channels 4..1
// - Register B holds channel 5, rest zero
// - All selectors clear on any reset
// - Channel 5 follows its selector in PWM
module pwm_timebase_select
  import pwmtb_pkg::*;
#(
  // Channel count and timer count width
  parameter int CHANNELS = 5,
  parameter int CNT_W = 8
)(
  // Clock, enable and reset
  input wire logic clk,
  input wire logic clkEn,
  input wire logic nrst,
  // Wishbone slave
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic wbWe,
  input wire logic [3:0] wbAdr,
  input wire logic [3:0] wbSel,
  input wire logic [31:0] wbDatI,
  output logic [31:0] wbDatO,
  output logic wbAck,
  // Timers 2, 4, 6
  input wire logic [CNT_W-1:0] tmr2Count,
  input wire logic [CNT_W-1:0] tmr4Count,
  input wire logic [CNT_W-1:0] tmr6Count,
  input wire logic tmr2Match,
  input wire logic tmr4Match,
  input wire logic tmr6Match,
  // Channel side
  input wire logic [CHANNELS-1:0] chanPwmMode,
  output logic [CHANNELS*CNT_W-1:0] chanCount,
  output logic [CHANNELS-1:0] chanMatch
);

  // Reset synchroniser stages
  logic rstSync1;
  logic rstSync2;
  // Stored selector fields
  logic [7:0] selA;
  logic [1:0] selB;
  // All selectors side by side, channel 1 in the low two bits
  logic [2*CHANNELS-1:0] selAll;
  // Bus request decode
  logic access;
  logic hitA;
  logic hitB;
  logic wrStrobe;
  logic rdStrobe;

  // Address compare, shared by the write and read paths
  // Only four address bits are decoded, so the pair repeats every
  // sixteen bytes of a wider bus window
  function automatic logic regHit(input logic [3:0] adr, input logic [3:0] ofs);
    regHit = (adr == ofs);
  endfunction : regHit

  // Reset release through two flip-flops; assertion acts at once, while
  // release waits two edges so that every flop leaves reset on one edge
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rstSync1 <= 1'b0;
      rstSync2 <= 1'b0;
    end
    else
    begin
      rstSync1 <= 1'b1;
      rstSync2 <= rstSync1;
    end
  end

  // A request is new only while ack is low, so a master that holds its
  // strobe through the ack cycle is not taken a second time
  assign access = wbCyc && wbStb && !wbAck;
  // Writes need byte lane 0, which carries the whole 8-bit register
  assign wrStrobe = access && wbWe && wbSel[0];
  // Reads return the addressed register in the low byte
  assign rdStrobe = access && !wbWe;
  // Register hits
  assign hitA = regHit(wbAdr, PWMTB_OFS_SELECT_A);
  assign hitB = regHit(wbAdr, PWMTB_OFS_SELECT_B);

  // Bus acknowledge, one cycle after request, dropped next cycle
  // Unmapped offsets and masked writes are acknowledged as well, so a
  // stray access never stalls the bus; a low enable holds ack as it is
  always_ff @(posedge clk or negedge rstSync2)
  begin
    if (!rstSync2)
      wbAck <= 1'b0;
    else if (clkEn)
      wbAck <= access;
  end

  // Selector register A
  // All four fields are written together from one byte
  always_ff @(posedge clk or negedge rstSync2)
  begin
    if (!rstSync2)
      selA <= PWMTB_RST_SELECT_A;
    else if (clkEn && wrStrobe && hitA)
      selA <= wbDatI[7:0];
  end

  // Selector register B
  // Only the two implemented bits are stored; the rest cannot hold a value
  always_ff @(posedge clk or negedge rstSync2)
  begin
    if (!rstSync2)
      selB <= PWMTB_RST_SELECT_B[1:0];
    else if (clkEn && wrStrobe && hitB)
      selB <= wbDatI[PWMTB_POS_CH5+1:PWMTB_POS_CH5];
  end

  // Read data; unmapped offsets read zero
  // Zero outside the ack cycle, so the bus never sees stale data,
  // and a write cycle returns zero as well
  always_ff @(posedge clk or negedge rstSync2)
  begin
    if (!rstSync2)
      wbDatO <= 32'h0000_0000;
    else if (clkEn)
    begin
      if (rdStrobe && hitA)
        wbDatO <= {24'h00_0000, selA};
      else if (rdStrobe && hitB)
        wbDatO <= {30'h0000_0000, selB};
      else
        wbDatO <= 32'h0000_0000;
    end
  end

  // Flat selector vector, channel 1 lowest
  // Channel n takes bits 2n-1 and 2n-2, with channel 5 on top
  assign selAll = {selB, selA[PWMTB_POS_CH4+1:PWMTB_POS_CH4], selA[PWMTB_POS_CH3+1:PWMTB_POS_CH3],
                   selA[PWMTB_POS_CH2+1:PWMTB_POS_CH2], selA[PWMTB_POS_CH1+1:PWMTB_POS_CH1]};

  // Count multiplexer for one selector; reserved code gives zero
  // A misconfigured channel thus sees a timer stuck at zero rather
  // than borrowing another channel's time base
  function automatic logic [CNT_W-1:0] pickCount(input logic [1:0] sel,
      input logic [CNT_W-1:0] c2, input logic [CNT_W-1:0] c4, input logic [CNT_W-1:0] c6);
    unique case (sel)
      PWMTB_SEL_TMR2: pickCount = c2;
      PWMTB_SEL_TMR4: pickCount = c4;
      PWMTB_SEL_TMR6: pickCount = c6;
      PWMTB_SEL_RSVD: pickCount = '0;
    endcase
  endfunction : pickCount

  // Match multiplexer for one selector; reserved code gives none
  // A reserved code therefore never reloads the channel's period
  function automatic logic pickMatch(input logic [1:0] sel,
      input logic m2, input logic m4, input logic m6);
    unique case (sel)
      PWMTB_SEL_TMR2: pickMatch = m2;
      PWMTB_SEL_TMR4: pickMatch = m4;
      PWMTB_SEL_TMR6: pickMatch = m6;
      PWMTB_SEL_RSVD: pickMatch = 1'b0;
    endcase
  endfunction : pickMatch

  // Per-channel routing, registered
  // Registered so that every output leaves a flop; the channel sees
  // each timer one clock late, count and match alike
  // routing for channels 1 to 5
  genvar g;
  generate
    for (g = 0; g < CHANNELS; g++)
    begin : gRoute
      always_ff @(posedge clk or negedge rstSync2)
      begin
        if (!rstSync2)
        begin
          chanCount[g*CNT_W +: CNT_W] <= '0;
          chanMatch[g] <= 1'b0;
        end
        else if (clkEn)
        begin
          // Count and match switch together, so a channel never pairs one
          // timer's count with another timer's match
          if (chanPwmMode[g])
          begin
            chanCount[g*CNT_W +: CNT_W] <= pickCount(selAll[2*g +: 2],
                tmr2Count, tmr4Count, tmr6Count);
            chanMatch[g] <= pickMatch(selAll[2*g +: 2], tmr2Match, tmr4Match, tmr6Match);
          end
          else
          begin
            // Outside PWM mode the channel gets no time base
            chanCount[g*CNT_W +: CNT_W] <= '0;
            chanMatch[g] <= 1'b0;
          end
        end
      end
    end
  endgenerate

endmodule : pwm_timebase_select
`default_nettype wire

// ===== verification/pwmtb_monitor.sv
// Port checker for the PWM time-base selector
`timescale 1ns/100ps
`default_nettype none
module pwmtb_monitor
  import pwmtb_pkg::*;
#(
  parameter int CHANNELS = 5,
  parameter int CNT_W = 8
)(
  // Clock, enable and reset
  input wire logic clk,
  input wire logic clkEn,
  input wire logic nrst,
  // Bus
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic wbWe,
  input wire logic [3:0] wbAdr,
  input wire logic [3:0] wbSel,
  input wire logic [31:0] wbDatI,
  input wire logic [31:0] wbDatO,
  input wire logic wbAck,
  // Timers
  input wire logic [CNT_W-1:0] tmr2Count,
  input wire logic [CNT_W-1:0] tmr4Count,
  input wire logic [CNT_W-1:0] tmr6Count,
  input wire logic tmr2Match,
  input wire logic tmr4Match,
  input wire logic tmr6Match,
  // Channels
  input wire logic [CHANNELS-1:0] chanPwmMode,
  input wire logic [CHANNELS*CNT_W-1:0] chanCount,
  input wire logic [CHANNELS-1:0] chanMatch
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // Request taken and a read answered
  sequence sReq; wbCyc && wbStb && !wbAck && clkEn; endsequence
  sequence sRead; wbAck && !wbWe; endsequence
  a_ack_after_req: assert property (sReq |=> wbAck) else $error("no ack");
  a_ack_one_pulse: assert property (wbAck && clkEn |=> !wbAck) else $error("long ack");
  a_ack_has_cause: assert property ($rose(wbAck) |-> $past(wbCyc && wbStb)) else $error("ack");
  a_data_idle_zero: assert property (!wbAck |-> wbDatO == 32'h0) else $error("data");
  a_read_low_byte: assert property (sRead |-> wbDatO[31:8] == 24'h0) else $error("rd");
  a_selb_upper_zero: assert property (sRead ##0 wbAdr == PWMTB_OFS_SELECT_B
    |-> wbDatO[31:2] == 30'h0)
    else $error("b");
  a_idle_chan_zero: assert property (clkEn && !chanPwmMode[0] |=> chanCount[7:0] == 8'h0)
    else $error("idle");
  a_match_cause: assert property (clkEn && !(tmr2Match || tmr4Match || tmr6Match)
    |=> chanMatch == 5'h0) else $error("match");
endmodule : pwmtb_monitor
bind pwm_timebase_select pwmtb_monitor #(.CHANNELS(CHANNELS), .CNT_W(CNT_W)) mon (.*);
`default_nettype wire

// ===== verification/pwm_timebase_select_bench.sv
// Self-checking bench for the PWM time-base selector
`timescale 1ns/100ps
`default_nettype none
module pwm_timebase_select_bench
  import pwmtb_pkg::*;
;
  logic clk = 1'b0, clkEn = 1'b1, nrst = 1'b0, wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0, wbAck;
  logic tmr2Match = 1'b0, tmr4Match = 1'b0, tmr6Match = 1'b0;
  logic [3:0] wbAdr = 4'h0, wbSel = 4'h0;
  logic [31:0] wbDatI = 32'h0, wbDatO, rd;
  logic [7:0] tmr2Count = 8'h0, tmr4Count = 8'h0, tmr6Count = 8'h0;
  logic [4:0] chanPwmMode = 5'h0, chanMatch;
  logic [39:0] chanCount;
  int failures = 0, n_compared = 0, selA = 0, selB = 0, sl, d, a, s;
  // Model's last expected routing, per channel
  int expCnt [5];
  int expMat [5];
  pwm_timebase_select dut (.*);
  initial forever #5 clk = ~clk;
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic stop_test;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : stop_test
  // One classic cycle, held until ack is seen
  task automatic wb(input logic we, input logic [3:0] ad, input logic [31:0] dt, input logic [3:0] se);
    int i;
    i = 0;
    @(posedge clk);
    {wbCyc, wbStb, wbWe, wbAdr, wbDatI, wbSel} <= {2'b11, we, ad, dt, se};
    do @(posedge clk); while (wbAck !== 1'b1 && ++i < 20);
    rd = wbDatO;
    {wbCyc, wbStb} <= 2'b00;
    if (i >= 20)
    begin
      failures++;
      stop_test();
    end
  endtask : wb
  function automatic int pick(int k, int x2, int x4, int x6);
    return k == 0 ? x2 : k == 1 ? x4 : k == 2 ? x6 : 0;
  endfunction : pick
  // New random timer inputs and modes, then two edges for the registered routing
  task automatic new_timers;
    {tmr2Count, tmr4Count, tmr6Count, tmr2Match, tmr4Match, tmr6Match, chanPwmMode} <= $urandom;
    repeat (2) @(posedge clk);
  endtask : new_timers
  // Model one channel from its selector, then compare count and match
  task automatic chk_chan(input int n);
    sl = n < 4 ? selA >> (2 * n) & 3 : selB;
    expCnt[n] = chanPwmMode[n] ? pick(sl, tmr2Count, tmr4Count, tmr6Count) : 0;
    expMat[n] = chanPwmMode[n] ? pick(sl, tmr2Match, tmr4Match, tmr6Match) : 0;
    chk("count", chanCount[8*n+:8], expCnt[n]);
    chk("match", chanMatch[n], expMat[n]);
  endtask : chk_chan
  initial
  begin
    void'($urandom(80));
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    wb(1'b0, PWMTB_OFS_SELECT_A, 0, 4'hf); chk("selA", rd, 0);
    wb(1'b0, PWMTB_OFS_SELECT_B, 0, 4'hf); chk("selB", rd, 0);
    wb(1'b0, 4'h8, 0, 4'hf); chk("unmapped", rd, 0);
    repeat (40)
    begin
      a = $urandom % 3 * 4; d = $urandom; s = $urandom;
      wb(1'b1, a[3:0], d, s[3:0]);
      if (s[0] && a == 0) selA = d & 255;
      if (s[0] && a == 4) selB = d & 3;
      wb(1'b0, PWMTB_OFS_SELECT_A, 0, 4'hf); chk("selA", rd, selA);
      wb(1'b0, PWMTB_OFS_SELECT_B, 0, 4'hf); chk("selB", rd, selB);
      new_timers();
      chk_chan(0);
      chk_chan(1);
      chk_chan(2);
      chk_chan(3);
      chk_chan(4);
    end
    // Nonzero selectors, then a reset in mid-run must clear them all
    wb(1'b1, PWMTB_OFS_SELECT_A, 32'h0000_00e7, 4'h1);
    wb(1'b1, PWMTB_OFS_SELECT_B, 32'h0000_00fe, 4'h1);
    nrst <= 1'b0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    selA = 0;
    selB = 0;
    repeat (4) @(posedge clk);
    wb(1'b0, PWMTB_OFS_SELECT_A, 0, 4'hf); chk("selA after reset", rd, 0);
    wb(1'b0, PWMTB_OFS_SELECT_B, 0, 4'hf); chk("selB after reset", rd, 0);
    new_timers();
    for (int n = 0; n < 5; n++)
      chk_chan(n);
    // Enable low: routing holds although the timers move, then catches up
    clkEn <= 1'b0;
    new_timers();
    for (int n = 0; n < 5; n++)
    begin
      chk("frozen count", chanCount[8*n+:8], expCnt[n]);
      chk("frozen match", chanMatch[n], expMat[n]);
    end
    clkEn <= 1'b1;
    repeat (2) @(posedge clk);
    for (int n = 0; n < 5; n++)
      chk_chan(n);
    stop_test();
  end
endmodule : pwm_timebase_select_bench
`default_nettype wire
